//--- logic/virtual_digital_io_bank.sv
// Virtual digital input and output bank with register port and fault
//
// Notes on behaviour
// - Sixteen virtual inputs, each takes an input function like hardware.
// - Nonzero virtual function matching a hardware input function faults while inputs are enabled.
// - Levels start from power-on default, then follow the level word.
// - Bit n of default and level words drives virtual input n+1.
// - Input logic zero means high-level active, one means edge active.
// - One-bit input enable, reset zero, immediate; host sets it stopped.
// - Power-on default word resets zero and applies after next power cycle.
// - Level word accepted any time, applied immediately, bit 0 is input one.
// - Sixteen virtual outputs, each assignable an output function.
// - Output logic zero means high-level active, one means low-level active.
// - One-bit output enable, reset zero, immediate; host changes it stopped.
// - Default-level word for unassigned outputs, reset zero, immediate.
// - Read-only output level word, reset zero, bit n is output n+1.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module virtual_digital_io_bank
    import vio_pkg::*;
#(
    parameter int N = N_IO,
    parameter int FW = FUNC_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    // Function assignment from parameter store
    input wire logic [N*FW-1:0] virtual_input_func,
    input wire logic [N*FW-1:0] hardware_input_func,
    input wire logic [N*FW-1:0] virtual_output_func,
    // Output function levels from the drive core
    input wire logic [N-1:0] output_function_level,
    // Stored power-on default as kept in nonvolatile memory
    input wire logic [DATA_W-1:0] stored_poweron_default,
    // Virtual input levels and active modes toward the function logic
    output logic [N-1:0] virtual_input,
    output logic [N-1:0] virtual_input_edge_mode,
    output logic virtual_input_active,
    // Virtual outputs
    output logic [N-1:0] virtual_output,
    output logic [N-1:0] virtual_output_low_active,
    // Fault and interrupt
    output logic duplicate_input_function_fault,
    output logic irq
);
    initial begin
        if (N != N_IO || FW < 1 || FW > DATA_W) begin
            $error("Unsupported bank width or function width");
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register state
    logic in_enable;
    logic [DATA_W-1:0] in_poweron;
    logic [DATA_W-1:0] in_level;
    logic out_enable;
    logic [DATA_W-1:0] out_default;
    logic [DATA_W-1:0] in_polarity;
    logic [DATA_W-1:0] out_polarity;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    level_src_t level_src;
    level_src_t next_level_src;

    ////////////////////////////////////////////////////////////////////
    // Address decode
    wire logic wr_in_en = reg_write && reg_addr == OFF_IN_EN;
    wire logic wr_in_pon = reg_write && reg_addr == OFF_IN_PON;
    wire logic wr_in_level = reg_write && reg_addr == OFF_IN_LEVEL;
    wire logic wr_out_en = reg_write && reg_addr == OFF_OUT_EN;
    wire logic wr_out_def = reg_write && reg_addr == OFF_OUT_DEF;
    wire logic wr_irq_stat = reg_write && reg_addr == OFF_IRQ_STAT;
    wire logic wr_irq_mask = reg_write && reg_addr == OFF_IRQ_MASK;
    wire logic wr_in_pol = reg_write && reg_addr == OFF_IN_POL;
    wire logic wr_out_pol = reg_write && reg_addr == OFF_OUT_POL;

    ////////////////////////////////////////////////////////////////////
    // Duplicate function detection
    // Each virtual function is compared with every hardware one
    logic [N-1:0] dup_hit;
    genvar gv;
    genvar gh;
    generate
        for (gv = 0; gv < N; gv++) begin : g_vin
            logic [N-1:0] match;
            for (gh = 0; gh < N; gh++) begin : g_hin
                assign match[gh] = virtual_input_func[gv*FW +: FW]
                    == hardware_input_func[gh*FW +: FW];
            end
            assign dup_hit[gv] =
                virtual_input_func[gv*FW +: FW] != FW'(FUNC_NONE)
                && |match;
        end
    endgenerate
    wire logic dup_now = in_enable && |dup_hit;

    ////////////////////////////////////////////////////////////////////
    // Level source selection and output composition
    logic [N-1:0] out_assigned;
    generate
        for (gv = 0; gv < N; gv++) begin : g_vout
            assign out_assigned[gv] =
                virtual_output_func[gv*FW +: FW] != FW'(FUNC_NONE);
        end
    endgenerate
    // Unassigned outputs show the host default, the rest their function
    wire logic [N-1:0] next_out = out_enable ? ((out_assigned &
        output_function_level) | (~out_assigned & out_default[N-1:0])) :
        '0;
    // Set wins over a write-one clear landing in the same cycle
    wire logic [IRQ_W-1:0] irq_event = {wr_in_level, dup_now};
    wire logic [IRQ_W-1:0] next_irq_status = irq_event |
        (irq_status & ~(wr_irq_stat ? reg_wdata[IRQ_W-1:0] : '0));
    // Next mask feeds the line so a mask write acts with no extra lag
    wire logic [IRQ_W-1:0] next_irq_mask = wr_irq_mask ?
        reg_wdata[IRQ_W-1:0] : irq_mask;

    always_comb begin
        next_level_src = level_src;
        unique case (level_src)
            // A level word in the very first cycle still goes live
            ST_POWERON: next_level_src = wr_in_level ? ST_LIVE : ST_LOADED;
            ST_LOADED: if (wr_in_level) begin
                next_level_src = ST_LIVE;
            end
            ST_LIVE: next_level_src = ST_LIVE;
            default: next_level_src = ST_POWERON;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (reg_addr)
            OFF_IN_EN: rd_mux = {{(DATA_W-1){1'b0}}, in_enable};
            OFF_IN_PON: rd_mux = in_poweron;
            OFF_IN_LEVEL: rd_mux = in_level;
            OFF_OUT_EN: rd_mux = {{(DATA_W-1){1'b0}}, out_enable};
            OFF_OUT_DEF: rd_mux = out_default;
            OFF_OUT_VIEW: rd_mux = virtual_output;
            OFF_IRQ_STAT: rd_mux = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
            OFF_IRQ_MASK: rd_mux = {{(DATA_W-IRQ_W){1'b0}}, irq_mask};
            OFF_IN_POL: rd_mux = in_polarity;
            OFF_OUT_POL: rd_mux = out_polarity;
            default: rd_mux = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            in_enable <= 1'b0;
            out_enable <= 1'b0;
            in_poweron <= RST_WORD;
            in_level <= RST_WORD;
            out_default <= RST_WORD;
            in_polarity <= RST_WORD;
            out_polarity <= RST_WORD;
            irq_mask <= '0;
        end else begin
            if (wr_in_en) in_enable <= reg_wdata[0];
            if (wr_out_en) out_enable <= reg_wdata[0];
            // Stored only; inputs keep the snapshot until a level word write or the next reset
            if (wr_in_pon) in_poweron <= reg_wdata;
            if (wr_in_level) in_level <= reg_wdata;
            if (wr_out_def) out_default <= reg_wdata;
            if (wr_in_pol) in_polarity <= reg_wdata;
            if (wr_out_pol) out_polarity <= reg_wdata;
            irq_mask <= next_irq_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power-on snapshot of the default used as input source before the level word
    logic [N-1:0] poweron_snap;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            poweron_snap <= '0;
        end else if (level_src == ST_POWERON) begin
            poweron_snap <= stored_poweron_default[N-1:0];
        end
    end
    wire logic [N-1:0] boot_level = (level_src == ST_LIVE) ?
        in_level[N-1:0] : poweron_snap;
    wire logic [N-1:0] next_in_sel = in_enable ? boot_level : '0;

    ////////////////////////////////////////////////////////////////////
    // Outputs and status
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            level_src <= ST_POWERON;
            virtual_input <= '0;
            virtual_input_edge_mode <= '0;
            virtual_input_active <= 1'b0;
            virtual_output <= '0;
            virtual_output_low_active <= '0;
            duplicate_input_function_fault <= 1'b0;
            irq_status <= '0;
            irq <= 1'b0;
            reg_rdata <= '0;
        end else begin
            level_src <= next_level_src;
            virtual_input <= next_in_sel;
            virtual_input_edge_mode <= in_polarity[N-1:0];
            virtual_input_active <= in_enable;
            virtual_output <= next_out;
            virtual_output_low_active <= out_polarity[N-1:0];
            duplicate_input_function_fault <= dup_now;
            irq_status <= next_irq_status;
            irq <= |(next_irq_status & next_irq_mask);
            reg_rdata <= reg_read ? rd_mux : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_dup_fault_follows: assert property (
        dup_now |=> duplicate_input_function_fault)
        else $error("Duplicate function did not raise fault");

    a_no_dup_clear: assert property (
        !dup_now |=> !duplicate_input_function_fault)
        else $error("Fault raised without duplicate");

    a_fault_needs_enable: assert property (
        !in_enable |=> !duplicate_input_function_fault)
        else $error("Fault raised while inputs disabled");

    a_level_live_apply: assert property (
        wr_in_level && in_enable ##1 in_enable |=>
        virtual_input == $past(reg_wdata, 2))
        else $error("Level word not applied");

    a_disabled_inputs_idle: assert property (
        !in_enable |=> virtual_input == '0)
        else $error("Inputs asserted while disabled");

    a_poweron_before_write: assert property (
        level_src == ST_LOADED && in_enable |=>
        virtual_input == poweron_snap)
        else $error("Input level not from power-on default");

    a_live_sticks: assert property (
        level_src == ST_LIVE |=> level_src == ST_LIVE)
        else $error("Level source left the level word");

    // Power-on snapshot may change only in the cycle after reset
    a_snap_held: assert property (
        level_src != ST_POWERON |=> $stable(poweron_snap))
        else $error("Power-on snapshot changed after start");

    a_out_disabled_zero: assert property (
        !out_enable |=> virtual_output == '0)
        else $error("Outputs driven while disabled");

    a_out_unassigned_def: assert property (
        out_enable && !out_assigned[0] |=>
        virtual_output[0] == $past(out_default[0]))
        else $error("Unassigned output not at default");

    a_out_assigned_follow: assert property (
        out_enable && out_assigned[0] |=>
        virtual_output[0] == $past(output_function_level[0]))
        else $error("Assigned output not at function level");

    // Read data must show the outputs as they stood at the strobe
    a_view_readback: assert property (
        reg_read && reg_addr == OFF_OUT_VIEW |=>
        reg_rdata == $past(virtual_output))
        else $error("Output view mismatch");

    a_rdata_idle: assert property (
        !reg_read |=> reg_rdata == '0)
        else $error("Read data outside read cycle");

    // Register stores and the outputs they drive
    a_in_enable_write: assert property (
        wr_in_en |=> in_enable == $past(reg_wdata[0]))
        else $error("Input enable not stored");

    a_active_follow: assert property (
        wr_in_en |=> ##1 virtual_input_active == $past(reg_wdata[0], 2))
        else $error("Input active flag not applied");

    a_out_enable_write: assert property (
        wr_out_en |=> out_enable == $past(reg_wdata[0]))
        else $error("Output enable not stored");

    a_pon_store: assert property (
        wr_in_pon |=> in_poweron == $past(reg_wdata))
        else $error("Power-on default not stored");

    a_level_store: assert property (
        wr_in_level |=> in_level == $past(reg_wdata))
        else $error("Level word not stored");

    a_out_default_store: assert property (
        wr_out_def |=> out_default == $past(reg_wdata))
        else $error("Output default not stored");

    a_in_pol_store: assert property (
        wr_in_pol |=> in_polarity == $past(reg_wdata))
        else $error("Input edge-mode word not stored");

    a_out_pol_store: assert property (
        wr_out_pol |=> out_polarity == $past(reg_wdata))
        else $error("Output low-active word not stored");

    a_edge_mode_map: assert property (
        wr_in_pol |=> ##1 virtual_input_edge_mode ==
        $past(reg_wdata, 2))
        else $error("Edge mode not applied");

    a_low_active_map: assert property (
        wr_out_pol |=> ##1 virtual_output_low_active ==
        $past(reg_wdata, 2))
        else $error("Low active not applied");

    // Interrupt status and line
    a_irq_dup_sticky: assert property (
        dup_now |=> irq_status[IRQ_DUP])
        else $error("Duplicate event not latched");

    a_irq_level_event: assert property (
        wr_in_level |=> irq_status[IRQ_LEVEL])
        else $error("Level word event not latched");

    a_irq_clear: assert property (
        wr_irq_stat && reg_wdata[IRQ_DUP] && !dup_now |=>
        !irq_status[IRQ_DUP])
        else $error("Duplicate status not cleared");

    a_irq_raise: assert property (
        irq_status[IRQ_DUP] && irq_mask[IRQ_DUP] && !wr_irq_mask &&
        !wr_irq_stat |=> irq)
        else $error("Unmasked status did not raise interrupt");

    a_irq_masked: assert property (
        next_irq_mask == '0 |=> !irq)
        else $error("Interrupt raised while all masked");

    c_live_switch: cover property (level_src == ST_LOADED ##1
        level_src == ST_LIVE);
    c_dup_fault: cover property (duplicate_input_function_fault);
    c_irq: cover property (irq);
    c_out_driven: cover property (out_enable && |virtual_output);
    c_poweron_used: cover property (level_src == ST_LOADED &&
        |virtual_input);
endmodule
`default_nettype wire

//--- logic/vio_pkg.sv
// Package of register map, field layout and types for the virtual I/O bank
`default_nettype none
package vio_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int N_IO = 16;
    localparam int FUNC_W = 6;
    localparam logic [3:0] OFF_IN_EN = 4'h0;
    localparam logic [3:0] OFF_IN_PON = 4'h1;
    localparam logic [3:0] OFF_IN_LEVEL = 4'h2;
    localparam logic [3:0] OFF_OUT_EN = 4'h3;
    localparam logic [3:0] OFF_OUT_DEF = 4'h4;
    localparam logic [3:0] OFF_OUT_VIEW = 4'h5;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h6;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h7;
    localparam logic [3:0] OFF_IN_POL = 4'h8;
    localparam logic [3:0] OFF_OUT_POL = 4'h9;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [FUNC_W-1:0] FUNC_NONE = 6'h00;
    localparam int IRQ_DUP = 0;
    localparam int IRQ_LEVEL = 1;
    localparam int IRQ_W = 2;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic write;
        logic read;
    } bus_req_t;
    typedef enum logic [1:0] {
        ST_POWERON = 2'h0,
        ST_LOADED = 2'h1,
        ST_LIVE = 2'h3
    } level_src_t;
endpackage
`default_nettype wire

//--- test/host_model.sv
// Host model driving the register port of the virtual I/O bank
`timescale 1ns/100ps
`default_nettype none
module host_model
    import vio_pkg::*;
(
    // Clock
    input wire logic clock,
    // Register port
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [DATA_W-1:0] reg_rdata
);
    initial begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    // Enables and defaults are written only with the drive stopped
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule
`default_nettype wire

//--- test/test_virtual_digital_io_bank.sv
// Self-checking bench of the virtual digital I/O bank
`timescale 1ns/100ps
`default_nettype none
module test_virtual_digital_io_bank;
    import vio_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_write;
    logic reg_read;
    logic [N_IO*FUNC_W-1:0] vfunc = '0;
    logic [N_IO*FUNC_W-1:0] hfunc = '0;
    logic [N_IO*FUNC_W-1:0] ofunc = '0;
    logic [15:0] ofl = 16'h0000;
    logic [15:0] pon = 16'h0000;
    logic [15:0] vin, vedge, vout, vlow, rv, lvl, def;
    logic vact, fault, irq;
    logic [3:0] ra [6];
    logic [15:0] lv4 [4];
    int err_total = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'h00006C87;

    always #4 clock = ~clock;

    host_model u_host_model (.clock(clock), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata));
    virtual_digital_io_bank u_virtual_digital_io_bank (.clock(clock),
        .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .virtual_input_func(vfunc), .hardware_input_func(hfunc),
        .virtual_output_func(ofunc), .output_function_level(ofl),
        .stored_poweron_default(pon), .virtual_input(vin),
        .virtual_input_edge_mode(vedge), .virtual_input_active(vact),
        .virtual_output(vout), .virtual_output_low_active(vlow),
        .duplicate_input_function_fault(fault), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    function automatic logic [15:0] exp_out(input logic en,
        input logic [95:0] f, input logic [15:0] lv, input logic [15:0] d);
        logic [15:0] r;
        for (int i = 0; i < 16; i++) begin
            r[i] = (f[6*i+:6] == FUNC_NONE) ? d[i] : lv[i];
        end
        return en ? r : 16'h0000;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        err_total++;
        end_of_test();
    end

    initial begin
        pon = rnd();
        ra = '{OFF_IN_EN, OFF_IN_PON, OFF_OUT_EN, OFF_OUT_DEF,
            OFF_OUT_VIEW, 4'hF};
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        u_host_model.wr(4'hF, 16'hFFFF);
        for (int i = 0; i < 6; i++) begin
            u_host_model.rd(ra[i], rv);
            chk(rv, RST_WORD);
        end
        $display("test reset done");
        // Power-on snapshot drives inputs until the level word is written
        u_host_model.wr(OFF_IN_EN, 16'h0001);
        settle();
        chk(vin, pon);
        chk({15'h0000, vact}, 16'h0001);
        def = rnd();
        u_host_model.wr(OFF_IN_PON, def);
        u_host_model.rd(OFF_IN_PON, rv);
        chk(rv, def);
        settle();
        chk(vin, pon);
        lv4 = '{16'h0001, 16'h8000, rnd(), rnd()};
        for (int k = 0; k < 4; k++) begin
            u_host_model.wr(OFF_IN_LEVEL, lv4[k]);
            settle();
            chk(vin, lv4[k]);
            u_host_model.rd(OFF_IN_LEVEL, rv);
            chk(rv, lv4[k]);
        end
        u_host_model.wr(OFF_IN_EN, 16'h0000);
        settle();
        chk(vin, 16'h0000);
        rv = rnd();
        u_host_model.wr(OFF_IN_POL, rv);
        u_host_model.wr(OFF_OUT_POL, ~rv);
        settle();
        chk(vedge, rv);
        chk(vlow, ~rv);
        u_host_model.rd(OFF_IN_POL, lvl);
        chk(lvl, rv);
        $display("test inputs done");
        for (int k = 0; k < 3; k++) begin
            def = rnd();
            lvl = rnd();
            rv = rnd();
            @(posedge clock);
            for (int i = 0; i < 16; i++) begin
                ofunc[6*i+:6] <= rv[i] ? 6'h0A : FUNC_NONE;
            end
            ofl <= lvl;
            u_host_model.wr(OFF_OUT_DEF, def);
            u_host_model.wr(OFF_OUT_EN, (k == 1) ? 16'h0000 : 16'h0001);
            settle();
            chk(vout, exp_out(k != 1, ofunc, lvl, def));
            u_host_model.wr(OFF_OUT_VIEW, 16'hFFFF);
            u_host_model.rd(OFF_OUT_VIEW, rv);
            chk(rv, exp_out(k != 1, ofunc, lvl, def));
        end
        u_host_model.rd(OFF_OUT_EN, rv);
        chk(rv, 16'h0001);
        $display("test outputs done");
        @(posedge clock);
        for (int i = 0; i < 16; i++) begin
            hfunc[6*i+:6] <= (i == 15) ? FUNC_NONE : 6'(i + 1);
            vfunc[6*i+:6] <= (i == 4) ? FUNC_NONE : 6'(i + 32);
        end
        u_host_model.wr(OFF_IN_EN, 16'h0001);
        u_host_model.wr(OFF_IRQ_MASK, 16'h0001);
        u_host_model.rd(OFF_IRQ_STAT, rv);
        chk(rv, 16'h0002);
        u_host_model.wr(OFF_IRQ_STAT, 16'h0003);
        settle();
        chk({14'h0000, fault, irq}, 16'h0000);
        @(posedge clock);
        vfunc[6*7+:6] <= 6'h03;
        settle();
        chk({14'h0000, fault, irq}, 16'h0003);
        u_host_model.rd(OFF_IRQ_STAT, rv);
        chk({15'h0000, rv[IRQ_DUP]}, 16'h0001);
        @(posedge clock);
        vfunc[6*7+:6] <= 6'h27;
        settle();
        chk({14'h0000, fault, irq}, 16'h0001);
        u_host_model.wr(OFF_IRQ_STAT, 16'h0001);
        u_host_model.wr(OFF_IRQ_MASK, 16'h0000);
        settle();
        chk({15'h0000, irq}, 16'h0000);
        u_host_model.rd(OFF_IRQ_STAT, rv);
        chk(rv, 16'h0000);
        @(posedge clock);
        vfunc[6*7+:6] <= 6'h03;
        settle();
        chk({14'h0000, fault, irq}, 16'h0002);
        u_host_model.rd(OFF_IRQ_STAT, rv);
        chk(rv, 16'h0001);
        $display("test fault done");
        end_of_test();
    end
endmodule
`default_nettype wire
